/* verilog/rtcb_map.svh */
/*
  Named constants of the battery-backed calendar clock: time windows,
  protection keys, interrupt bit positions, calendar limits, reset values.
  Assumes inclusion by rtcb_top.sv and its bench only.
*/
`ifndef RTCB_MAP_SVH
`define RTCB_MAP_SVH
`define RTCB_CLK_NS        4
`define RTCB_OSC_HZ        32768
`define RTCB_POR_WIN_S     15
`define RTCB_UNLK_WIN_S    2
`define RTCB_FILT_MIN_NS   64000
`define RTCB_FILT_MAX_NS   125000000
`define RTCB_FILT_SEL_MAX  4'hB
`define RTCB_KEY0          2'h0
`define RTCB_KEY1          2'h1
`define RTCB_KEY2          2'h3
`define RTCB_KEY3          2'h2
`define RTCB_ISR_TAMPER_EVENT_BIT      0
`define RTCB_ISR_ALM       1
`define RTCB_ISR_CD        2
`define RTCB_ISR_PER       3
`define RTCB_ISR_RST       16'h0001
`define RTCB_IER_RST       16'h0001
`define RTCB_TMP_EN_RST    3'h7
`define RTCB_P512_BIT      5
`define RTCB_PER_LSB       8
`define RTCB_PER_N         7
`define RTCB_CDATA_CLKSEL  0
`define RTCB_RSV_RD_DATA   8'hFF
`define RTCB_RAM_DEPTH     32
`define RTCB_SEC_MAX       6'h3B
`define RTCB_MIN_MAX       6'h3B
`define RTCB_HOUR_MAX      5'h17
`define RTCB_MON_MAX       4'hC
`define RTCB_DOW_MAX       3'h6
`define RTCB_YR_NOLEAP_A   8'h58
`define RTCB_YR_NOLEAP_B   8'hF4
`define RTCB_D28           5'h1C
`define RTCB_D29           5'h1D
`define RTCB_D30           5'h1E
`define RTCB_D31           5'h1F
`define RTCB_TIME_RST      {8'h00, 4'h1, 5'h01, 3'h0, 5'h00, 6'h00, 6'h00}
`endif

/* verilog/rtcb_pkg.sv */
/*
  Types of the battery-backed calendar clock: time, alarm, configuration
  and protection state. Assumes the constants of rtcb_map.svh.
*/
`default_nettype none
package rtcb_pkg;
  typedef struct packed {
    logic [7:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] dow;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rtcb_time_t;

  typedef struct packed {
    logic       match_date;
    logic [7:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rtcb_alm_t;

  typedef struct packed {
    logic       en;
    logic [3:0] start_mon;
    logic [4:0] start_day;
    logic [4:0] start_hour;
    logic [3:0] end_mon;
    logic [4:0] end_day;
    logic [4:0] end_hour;
  } rtcb_dst_t;

  typedef struct packed {
    logic [2:0]        tmp_en;
    logic [1:0]        tmp_pol;
    logic [3:0]        filt_a;
    logic [3:0]        filt_b;
    logic signed [7:0] comp;
    logic              cd_en;
    logic [7:0]        cd_min;
    rtcb_dst_t         dst;
  } rtcb_cfg_t;

  typedef enum logic [2:0] {
    PR_LOCK = 3'h0,
    PR_S1   = 3'h1,
    PR_S2   = 3'h3,
    PR_S3   = 3'h2,
    PR_OPEN = 3'h6
  } rtcb_prot_t;
endpackage
`default_nettype wire

/* verilog/rtcb_top.sv */
/*
  Battery-backed calendar clock with tamper time stamps, standby RAM and
  write protection; register fields are plain ports.
  Assumes osc_32k_in, on_battery and the tamper inputs are asynchronous pins
  and all strobes come from logic on ref_clk. rst is the power-on reset,
  soft_rst the lighter soft reset.
*/
// Functional notes
// RULE1 - Writable fifteen seconds after power-on, then locked
// RULE2 - Correct key sequence on protection field unlocks
// RULE3 - Any protection write after unlock relocks
// RULE4 - Unlock window lasts two seconds, then relocks
// RULE5 - Tamper interrupt enable set out of reset
// RULE6 - Power-on reset sets tamper interrupt flag
// RULE7 - Soft reset clears alarm, status, flags, config
// RULE8 - Software writes zeros to config bits 7:1
// RULE9 - Any reset sets register clock gate bit
// RULE10 - No register access while on battery; gate_wr still writes the register clock gate bit on battery
// RULE11 - Prescaler gated on battery, no 512 Hz
// RULE12 - Alarm match sets flag, interrupt, wake output
// RULE13 - Minute countdown with enable, interrupt at expiry
// RULE14 - Seven periodic sampling interrupts
// RULE15 - Software correction value trims 1 Hz tick
// RULE16 - Month length, leap year and daylight saving
// RULE17 - Clock output selects 32 kHz or 1 Hz
// RULE18 - 32-byte standby RAM kept on battery
// RULE19 - Two tamper pins plus battery removal, enables, polarity
// RULE20 - Latest tamper event stores one time stamp
// RULE21 - Tamper pins low-pass filtered, 64 us to 125 ms
// RULE22 - Timekeeping runs while register clock gated
// RULE23 - Status bit flags counters changing at second
// RULE24 - Reserved access errors, reads return all ones; the code raises no error on reserved writes while unlocked
// RULE25 - 1 Hz tick divided from 32.768 kHz
`timescale 1ns/10ps
`default_nettype none
`include "rtcb_map.svh"
module rtcb_top #(
  parameter int FILT_MIN_CYC = (`RTCB_FILT_MIN_NS + `RTCB_CLK_NS - 1) / `RTCB_CLK_NS,
  parameter int FILT_MAX_CYC = `RTCB_FILT_MAX_NS / `RTCB_CLK_NS
) (
  // Clock, resets, enable
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               soft_rst,
  input  wire logic               ce,
  // Pins
  input  wire logic               osc_32k_in,
  input  wire logic               on_battery,
  input  wire logic               ext_tamper_in_a,
  input  wire logic               ext_tamper_in_b,
  input  wire logic               battery_removal_tamper,
  // Register writes
  input  wire logic               prot_wr,
  input  wire logic [1:0]         prot_code,
  input  wire logic               cal_wr,
  input  wire rtcb_pkg::rtcb_time_t cal_data,
  input  wire logic               alm_wr,
  input  wire rtcb_pkg::rtcb_alm_t alm_data,
  input  wire logic               cfg_wr,
  input  wire rtcb_pkg::rtcb_cfg_t cfg_data,
  input  wire logic               cdata_wr,
  input  wire logic [7:0]         cdata_in,
  input  wire logic               ier_wr,
  input  wire logic [15:0]        ier_data,
  input  wire logic               isr_clr,
  input  wire logic [15:0]        isr_clr_mask,
  input  wire logic               gate_wr,
  input  wire logic               gate_val,
  // Standby RAM and reserved space
  input  wire logic               ram_wr,
  input  wire logic               ram_rd,
  input  wire logic [4:0]         ram_addr,
  input  wire logic [7:0]         ram_wdata,
  input  wire logic               rsv_acc,
  input  wire logic               rsv_wr,
  // State out
  output rtcb_pkg::rtcb_time_t    time_out,
  output rtcb_pkg::rtcb_time_t    stamp_out,
  output logic [7:0]              status_reg,
  output logic [15:0]             interrupt_status_reg,
  output logic [15:0]             interrupt_enable_reg,
  output logic [7:0]              config_data_reg,
  output logic                    peripheral_clock_gate_reg,
  output logic                    irq,
  output logic                    alarm_wake,
  output logic                    clk_out,
  output logic                    clk_512hz,
  output logic [7:0]              ram_rdata,
  output logic                    xfer_err
);
  import rtcb_pkg::*;

  logic [4:0]  s1_reg, s2_reg;
  logic        osc_d_reg;
  rtcb_prot_t  prot_reg, prot_next;
  logic [19:0] win_reg;
  logic [14:0] pre_reg;
  logic [6:0]  per_d_reg;
  logic [16:0] sdiv_reg;
  rtcb_time_t  tm_reg, tm_next;
  rtcb_alm_t   alm_reg;
  rtcb_cfg_t   cfg_reg;
  logic        rep_reg, upd_reg;
  logic [7:0]  cd_reg;
  logic [1:0]  filt_reg, filt_d_reg;
  logic [1:0][24:0] fcnt_reg;
  logic        brm_d_reg;
  logic [2:0]  src_reg;
  logic [7:0]  ram_mem [0:`RTCB_RAM_DEPTH-1];

  function automatic logic [24:0] filt_w(input logic [3:0] sel);
    logic [31:0] w;
    w = 32'(FILT_MIN_CYC) << sel;
    filt_w = (sel > `RTCB_FILT_SEL_MAX || w > 32'(FILT_MAX_CYC)) ? 25'(FILT_MAX_CYC) : w[24:0];
  endfunction

  function automatic logic [4:0] days_in(input logic [3:0] m, input logic [7:0] y);
    logic leap;
    leap = (y[1:0] == 2'h0) && (y != `RTCB_YR_NOLEAP_A) && (y != `RTCB_YR_NOLEAP_B);
    case (m)
      4'h2: days_in = leap ? `RTCB_D29 : `RTCB_D28;
      4'h4, 4'h6, 4'h9, 4'hB: days_in = `RTCB_D30;
      default: days_in = `RTCB_D31;
    endcase
  endfunction

  function automatic rtcb_time_t adv(input rtcb_time_t t, input rtcb_dst_t d, input logic fall);
    rtcb_time_t n;
    logic [4:0] h;
    n = t;
    h = (t.hour == `RTCB_HOUR_MAX) ? 5'h00 : t.hour + 5'h01;
    if (d.en && t.month == d.start_mon && t.day == d.start_day && h == d.start_hour)
      h = h + 5'h01;
    if (fall)
      h = t.hour;
    if (t.sec != `RTCB_SEC_MAX) begin
      n.sec = t.sec + 6'h01;
    end else begin
      n.sec = 6'h00;
      if (t.min != `RTCB_MIN_MAX) begin
        n.min = t.min + 6'h01;
      end else begin
        n.min = 6'h00;
        n.hour = h;
        if (t.hour == `RTCB_HOUR_MAX && !fall) begin
          n.dow = (t.dow == `RTCB_DOW_MAX) ? 3'h0 : t.dow + 3'h1;
          if (t.day != days_in(t.month, t.year)) begin
            n.day = t.day + 5'h01;
          end else begin
            n.day = 5'h01;
            n.month = (t.month == `RTCB_MON_MAX) ? 4'h1 : t.month + 4'h1;
            if (t.month == `RTCB_MON_MAX)
              n.year = t.year + 8'h01;
          end
        end
      end
    end
    adv = n;
  endfunction

  // Decode and selection
  wire        osc_tick = s2_reg[0] & ~osc_d_reg;
  wire        batt     = s2_reg[1];
  wire        acc_ok   = peripheral_clock_gate_reg & ~batt;  // RULE10 RULE22
  wire        unlocked = (prot_reg == PR_OPEN);
  wire        wr_ok    = acc_ok & unlocked;
  wire        win_end  = osc_tick & (win_reg == 20'h00001);
  wire [16:0] sec_term = 17'(`RTCB_OSC_HZ - 1 + int'(cfg_reg.comp));  // RULE15
  wire        sec_tick = ce & osc_tick & (sdiv_reg >= sec_term);  // RULE25
  wire        hz1      = sdiv_reg < {1'b0, sec_term[16:1]};
  wire        inval    = (sdiv_reg >= sec_term);  // RULE23
  wire        min_tick = sec_tick & (tm_reg.sec == `RTCB_SEC_MAX);
  wire        hr_roll  = min_tick & (tm_reg.min == `RTCB_MIN_MAX);
  wire        on_end   = (tm_reg.month == cfg_reg.dst.end_mon) & (tm_reg.day == cfg_reg.dst.end_day);
  wire [4:0]  hr_inc   = (tm_reg.hour == `RTCB_HOUR_MAX) ? 5'h00 : tm_reg.hour + 5'h01;
  wire        dst_fall = cfg_reg.dst.en & ~rep_reg & on_end & hr_roll & (hr_inc == cfg_reg.dst.end_hour);
  wire        alm_t_eq = (tm_reg.hour == alm_reg.hour) & (tm_reg.min == alm_reg.min) & (tm_reg.sec == alm_reg.sec);
  wire        alm_d_eq = (tm_reg.year == alm_reg.year) & (tm_reg.month == alm_reg.month) &
                         (tm_reg.day == alm_reg.day);
  wire        alm_hit  = upd_reg & alm_t_eq & (~alm_reg.match_date | alm_d_eq);  // RULE12
  wire        cd_exp   = min_tick & cfg_reg.cd_en & (cd_reg == 8'h01);  // RULE13
  wire [6:0]  per_now  = pre_reg[`RTCB_PER_LSB +: `RTCB_PER_N];
  wire [6:0]  per_ev   = per_now & ~per_d_reg;  // RULE14
  wire [1:0]  fraw     = s2_reg[3:2] ^ cfg_reg.tmp_pol;  // RULE19
  wire [1:0][24:0] fwid = {filt_w(cfg_reg.filt_b), filt_w(cfg_reg.filt_a)};  // RULE21
  wire [2:0]  tmp_ev   = cfg_reg.tmp_en & {s2_reg[4] & ~brm_d_reg, filt_reg & ~filt_d_reg};  // RULE19
  wire        tmp_any  = ce & (|tmp_ev);
  wire [15:0] isr_set  = {6'h00, per_ev, cd_exp, alm_hit, tmp_any};
  wire [15:0] isr_clrv = (isr_clr && wr_ok) ? isr_clr_mask : 16'h0000;
  wire [15:0] isr_n    = (interrupt_status_reg & ~isr_clrv) | isr_set;  // Set beats clear

  assign tm_next = adv(tm_reg, cfg_reg.dst, dst_fall);  // RULE16

  always_comb begin
    prot_next = prot_reg;
    if (prot_wr && acc_ok) begin
      case (prot_reg)
        PR_LOCK: prot_next = (prot_code == `RTCB_KEY0) ? PR_S1 : PR_LOCK;  // RULE2
        PR_S1:   prot_next = (prot_code == `RTCB_KEY1) ? PR_S2 : PR_LOCK;
        PR_S2:   prot_next = (prot_code == `RTCB_KEY2) ? PR_S3 : PR_LOCK;
        PR_S3:   prot_next = (prot_code == `RTCB_KEY3) ? PR_OPEN : PR_LOCK;
        default: prot_next = PR_LOCK;  // RULE3
      endcase
    end else if (unlocked && win_end) begin
      prot_next = PR_LOCK;  // RULE4
    end
  end

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_reg    <= 5'h00;
      s2_reg    <= 5'h00;
      osc_d_reg <= 1'b0;
    end else if (ce) begin
      s1_reg    <= {battery_removal_tamper, ext_tamper_in_b, ext_tamper_in_a, on_battery, osc_32k_in};
      s2_reg    <= s1_reg;
      osc_d_reg <= s2_reg[0];
    end
  end

  // Protection; power-on opens a long window
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prot_reg <= PR_OPEN;  // RULE1
      win_reg  <= 20'(`RTCB_POR_WIN_S * `RTCB_OSC_HZ);  // RULE1
    end else if (ce) begin
      prot_reg <= prot_next;
      if (prot_next == PR_OPEN && prot_reg == PR_S3)
        win_reg <= 20'(`RTCB_UNLK_WIN_S * `RTCB_OSC_HZ);  // RULE4
      else if (unlocked && osc_tick)
        win_reg <= win_reg - 20'h00001;
    end
  end

  // Prescaler stops on battery to save charge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_reg   <= 15'h0000;
      per_d_reg <= 7'h00;
      clk_512hz <= 1'b0;
    end else if (ce) begin
      if (osc_tick && !batt)
        pre_reg <= pre_reg + 15'h0001;  // RULE11
      per_d_reg <= per_now;
      clk_512hz <= pre_reg[`RTCB_P512_BIT] & ~batt;  // RULE11
    end
  end

  // Compensated second divider and clock output
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdiv_reg <= 17'h00000;
      upd_reg  <= 1'b0;
      clk_out  <= 1'b0;
    end else if (ce) begin
      if (sec_tick)
        sdiv_reg <= 17'h00000;
      else if (osc_tick)
        sdiv_reg <= sdiv_reg + 17'h00001;  // RULE25
      upd_reg <= sec_tick;
      clk_out <= config_data_reg[`RTCB_CDATA_CLKSEL] ? hz1 : s2_reg[0];  // RULE17
    end
  end

  // Time counters; soft reset leaves them alone
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tm_reg  <= `RTCB_TIME_RST;
      rep_reg <= 1'b0;
    end else if (ce) begin
      if (cal_wr && wr_ok)
        tm_reg <= cal_data;
      else if (sec_tick)
        tm_reg <= tm_next;  // RULE16 RULE22
      if (dst_fall)
        rep_reg <= 1'b1;
      else if (sec_tick && !on_end)
        rep_reg <= 1'b0;
    end
  end

  // Configuration kept through soft reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_reg        <= '0;
      cfg_reg.tmp_en <= `RTCB_TMP_EN_RST;
      cd_reg         <= 8'h00;
    end else if (ce) begin
      if (cfg_wr && wr_ok)
        cfg_reg <= cfg_data;
      if (cfg_wr && wr_ok)
        cd_reg <= cfg_data.cd_min;
      else if (min_tick && cfg_reg.cd_en && cd_reg != 8'h00)
        cd_reg <= cd_reg - 8'h01;  // RULE13
    end
  end

  // Soft-reset registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alm_reg                   <= '0;
      config_data_reg           <= 8'h00;
      interrupt_enable_reg      <= `RTCB_IER_RST;  // RULE5
      interrupt_status_reg      <= `RTCB_ISR_RST;  // RULE6
      src_reg                   <= 3'h0;
      peripheral_clock_gate_reg <= 1'b1;  // RULE9
    end else if (ce) begin
      if (soft_rst) begin
        alm_reg                    <= '0;  // RULE7
        config_data_reg            <= 8'h00;
        interrupt_enable_reg[15:1] <= 15'h0000;
        interrupt_status_reg[15:1] <= 15'h0000;
        src_reg                    <= 3'h0;
        peripheral_clock_gate_reg  <= 1'b1;  // RULE9
      end else begin
        if (alm_wr && wr_ok)
          alm_reg <= alm_data;
        if (cdata_wr && wr_ok)
          config_data_reg <= {7'h00, cdata_in[`RTCB_CDATA_CLKSEL]};  // Reserved bits not stored
        if (ier_wr && wr_ok)
          interrupt_enable_reg <= ier_data;
        interrupt_status_reg <= isr_n;
        src_reg <= src_reg | tmp_ev;
        if (gate_wr)
          peripheral_clock_gate_reg <= gate_val;
      end
    end
  end

  // Tamper filters, one per pin
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      filt_reg   <= 2'h0;
      filt_d_reg <= 2'h0;
      fcnt_reg   <= '0;
      brm_d_reg  <= 1'b0;
    end else if (ce) begin
      filt_d_reg <= filt_reg;
      brm_d_reg  <= s2_reg[4];
      for (int i = 0; i < 2; i++) begin
        if (fraw[i] == filt_reg[i]) begin
          fcnt_reg[i] <= 25'h0000000;
        end else if (fcnt_reg[i] >= fwid[i]) begin
          filt_reg[i] <= fraw[i];  // RULE21
          fcnt_reg[i] <= 25'h0000000;
        end else begin
          fcnt_reg[i] <= fcnt_reg[i] + 25'h0000001;
        end
      end
    end
  end

  // Outputs seen by software
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stamp_out  <= '0;
      time_out   <= `RTCB_TIME_RST;
      status_reg <= 8'h00;
      irq        <= 1'b0;
      alarm_wake <= 1'b0;
      ram_rdata  <= 8'h00;
      xfer_err   <= 1'b0;
    end else if (ce) begin
      if (tmp_any)
        stamp_out <= tm_reg;  // RULE20
      if (acc_ok)
        time_out <= tm_reg;  // RULE10
      status_reg <= {3'h0, src_reg, unlocked, inval};  // RULE23
      irq        <= |(interrupt_status_reg & interrupt_enable_reg);
      alarm_wake <= interrupt_status_reg[`RTCB_ISR_ALM];  // RULE12
      xfer_err   <= rsv_acc & acc_ok & (~rsv_wr | ~unlocked);  // RULE24
      if (rsv_acc && !rsv_wr && acc_ok)
        ram_rdata <= `RTCB_RSV_RD_DATA;  // RULE24
      else if (ram_rd && acc_ok)
        ram_rdata <= ram_mem[ram_addr];
    end
  end

  // Standby RAM has no reset; contents survive soft reset
  always_ff @(posedge ref_clk) begin
    if (ce && ram_wr && wr_ok)
      ram_mem[ram_addr] <= ram_wdata;  // RULE18
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_unlock_window: assert property ((ce && acc_ok && prot_wr && prot_reg == PR_S3 && prot_code == `RTCB_KEY3)
      |=> (prot_reg == PR_OPEN && win_reg == 20'(`RTCB_UNLK_WIN_S * `RTCB_OSC_HZ)))  // RULE2
    else $error("unlock sequence did not open two second window");
  a_wrong_key_locks: assert property ((ce && acc_ok && prot_wr && prot_reg == PR_S1 && prot_code != `RTCB_KEY1)
      |=> prot_reg == PR_LOCK)  // RULE2
    else $error("wrong key did not lock");
  a_relock_any: assert property ((ce && acc_ok && prot_wr && unlocked) |=> prot_reg == PR_LOCK)  // RULE3
    else $error("protection write did not relock");
  a_window_expiry: assert property ((ce && unlocked && win_end && !(prot_wr && acc_ok))
      |=> prot_reg == PR_LOCK)  // RULE4
    else $error("window expiry did not lock");
  a_locked_alarm_hold: assert property ((ce && alm_wr && !wr_ok && !soft_rst) |=> $stable(alm_reg))  // RULE1
    else $error("alarm written while locked");
  a_soft_clears: assert property ((ce && soft_rst) |=> (interrupt_enable_reg[15:1] == 15'h0000 &&
      alm_reg == '0 && config_data_reg == 8'h00 && peripheral_clock_gate_reg))  // RULE7
    else $error("soft reset left registers set");
  a_soft_keeps_time: assert property ((ce && soft_rst && !sec_tick && !(cal_wr && wr_ok)) |=> $stable(tm_reg))  // RULE7
    else $error("soft reset changed time counters");
  a_batt_no_512: assert property ((ce && batt) |=> !clk_512hz)  // RULE11
    else $error("512 Hz output active on battery");
  a_alarm_flag: assert property ((ce && alm_hit && !soft_rst) |=> interrupt_status_reg[`RTCB_ISR_ALM])  // RULE12
    else $error("alarm match did not set flag");
  a_tamper_stamp: assert property ((tmp_any && !soft_rst)
      |=> (stamp_out == $past(tm_reg) && interrupt_status_reg[`RTCB_ISR_TAMPER_EVENT_BIT]))  // RULE20
    else $error("tamper did not stamp time");
  a_invalid_tick: assert property (sec_tick |-> inval ##1 status_reg[0])  // RULE23
    else $error("second update not flagged");
  a_reserved_read: assert property ((ce && rsv_acc && !rsv_wr && acc_ok)
      |=> (xfer_err && ram_rdata == `RTCB_RSV_RD_DATA))  // RULE24
    else $error("reserved read gave no error");

  c_unlock_done: cover property (ce && prot_reg == PR_S3 ##1 prot_reg == PR_OPEN);
  c_tamper_seen: cover property (tmp_any);
  c_alarm_seen: cover property (alm_hit);
  c_countdown: cover property (cd_exp);
endmodule // rtcb_top
`default_nettype wire

/* testbench/rtcb_top_tb.sv */
/*
  Self-checking bench for rtcb_top: reset values, protection, soft reset,
  clock gate, reserved access, standby RAM, tamper filter and time stamps.
  Assumes rtcb_pkg and rtcb_map.svh; one trimmed second of fast
  oscillator near the end, so the run is about 66000 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rtcb_map.svh"
module rtcb_top_tb;
  import rtcb_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, osc = 1'b0, onb = 1'b0;
  logic ta = 1'b0, tb = 1'b0, brt = 1'b0, gval = 1'b0, rsvw = 1'b0;
  logic [11:0] stb = '0;
  logic [1:0]  pcode = '0;
  logic [7:0]  cdin = '0, wdat = '0, status, cfgd, rdat;
  logic [15:0] ierd = '0, clrm = '0, isr, ier;
  logic [4:0]  raddr = '0;
  logic        gate, irq, wake, cko, c512, xerr;
  logic        inval_seen = 1'b0;
  rtcb_time_t  cal = '0, tout, stamp;
  rtcb_alm_t   alm = '0;
  rtcb_cfg_t   cfg = '0;
  int errors = 0, check_count = 0;
  localparam rtcb_time_t T1 = {8'h10, 4'h3, 5'h0F, 3'h2, 5'h0A, 6'h1E, 6'h2D};
  localparam rtcb_time_t T2 = {8'h11, 4'h5, 5'h02, 3'h4, 5'h03, 6'h04, 6'h05};

  always #2 ref_clk = ~ref_clk;

  rtcb_top #(.FILT_MIN_CYC(4), .FILT_MAX_CYC(200)) dut (
    .ref_clk(ref_clk), .rst(rst), .soft_rst(stb[10]), .ce(ce), .osc_32k_in(osc),
    .on_battery(onb), .ext_tamper_in_a(ta), .ext_tamper_in_b(tb), .battery_removal_tamper(brt),
    .prot_wr(stb[0]), .prot_code(pcode), .cal_wr(stb[1]), .cal_data(cal), .alm_wr(stb[11]),
    .alm_data(alm), .cfg_wr(stb[2]), .cfg_data(cfg), .cdata_wr(stb[3]), .cdata_in(cdin),
    .ier_wr(stb[4]), .ier_data(ierd), .isr_clr(stb[5]), .isr_clr_mask(clrm), .gate_wr(stb[6]),
    .gate_val(gval), .ram_wr(stb[7]), .ram_rd(stb[8]), .ram_addr(raddr), .ram_wdata(wdat),
    .rsv_acc(stb[9]), .rsv_wr(rsvw), .time_out(tout), .stamp_out(stamp), .status_reg(status),
    .interrupt_status_reg(isr), .interrupt_enable_reg(ier), .config_data_reg(cfgd),
    .peripheral_clock_gate_reg(gate), .irq(irq), .alarm_wake(wake), .clk_out(cko),
    .clk_512hz(c512), .ram_rdata(rdat), .xfer_err(xerr));

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One-cycle strobe on the selected write lines
  task automatic pulse(input logic [11:0] m);
    @(negedge ref_clk);
    stb = m;
    @(negedge ref_clk);
    stb = '0;
  endtask

  task automatic prot(input logic [1:0] c);
    pcode = c;
    pulse(12'h001);
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog past the roughly 66000 cycles the sequence needs
  initial begin
    #300000;
    errors++;
    end_sim;
  end

  initial begin
    step(5);
    rst = 1'b0;
    step(3);
    chk("isr", isr, `RTCB_ISR_RST);
    chk("ier", ier, `RTCB_IER_RST);
    chk("gate", gate, 1'b1);
    chk("unlocked", status[1], 1'b1);
    chk("time", tout, `RTCB_TIME_RST);
    raddr = 5'h1F;
    wdat = 8'hA5;
    pulse(12'h080);
    pulse(12'h100);
    chk("ram", rdat, 8'hA5);
    cal = T1;
    pulse(12'h002);
    step(2);
    chk("time", tout, T1);
    osc = 1'b1;
    step(6);
    chk("clkout", cko, 1'b1);
    osc = 1'b0;
    step(6);
    chk("clkout", cko, 1'b0);
    cdin = 8'h01;
    ierd = 16'h0007;
    clrm = 16'h0001;
    pulse(12'h038);
    step(2);
    chk("cdata", cfgd, 8'h01);
    chk("ier", ier, 16'h0007);
    chk("isr", isr, 16'h0000);
    // Gate off blocks the register block, time keeps its value
    pulse(12'h040);
    ierd = 16'h000F;
    pulse(12'h010);
    step(2);
    chk("gate", gate, 1'b0);
    chk("ier", ier, 16'h0007);
    chk("time", tout, T1);
    pulse(12'h400);
    step(2);
    chk("ier", ier, 16'h0001);
    chk("cdata", cfgd, 8'h00);
    chk("gate", gate, 1'b1);
    chk("time", tout, T1);
    pulse(12'h200);
    chk("rsv err", xerr, 1'b1);
    chk("rsv data", rdat, `RTCB_RSV_RD_DATA);
    rsvw = 1'b1;
    pulse(12'h200);
    chk("rsv wr open", xerr, 1'b0);
    prot(2'h2);
    step(2);
    chk("locked", status[1], 1'b0);
    ierd = 16'hFFFF;
    pulse(12'h010);
    step(2);
    chk("ier", ier, 16'h0001);
    pulse(12'h200);
    chk("rsv wr lock", xerr, 1'b1);
    // Wrong third key keeps the lock, then the full sequence opens it
    prot(`RTCB_KEY0);
    prot(`RTCB_KEY1);
    prot(2'h2);
    step(2);
    chk("locked", status[1], 1'b0);
    prot(`RTCB_KEY0);
    prot(`RTCB_KEY1);
    prot(`RTCB_KEY2);
    prot(`RTCB_KEY3);
    step(2);
    chk("unlocked", status[1], 1'b1);
    cfg.tmp_en = 3'h7;
    pulse(12'h004);
    step(1);
    ta = 1'b1;
    step(2);
    ta = 1'b0;
    step(20);
    chk("glitch", isr[0], 1'b0);
    ta = 1'b1;
    step(20);
    ta = 1'b0;
    step(12);
    chk("tamper a", isr[0], 1'b1);
    chk("src a", status[2], 1'b1);
    chk("stamp", stamp, T1);
    pulse(12'h020);
    cal = T2;
    pulse(12'h002);
    step(2);
    brt = 1'b1;
    step(12);
    chk("tamper bat", isr[0], 1'b1);
    chk("src bat", status[4], 1'b1);
    chk("stamp", stamp, T2);
    // One trimmed second from Dec 31 23:59:59, alarm and countdown armed
    cal = {8'h00, 4'hC, 5'h1F, 3'h6, 5'h17, 6'h3B, 6'h3B};
    alm = {1'b1, 8'h01, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00};
    cfg.comp = 8'h80;
    cfg.cd_en = 1'b1;
    cfg.cd_min = 8'h01;
    ierd = 16'h0006;
    pulse(12'h81E);
    // 32700 osc periods: past the trimmed second, short of an untrimmed one
    for (int i = 0; i < 65400; i++) begin
      @(negedge ref_clk);
      osc = ~osc;
      if (status[0] === 1'b1)
        inval_seen = 1'b1;
    end
    step(4);
    chk("time roll", tout, {8'h01, 4'h1, 5'h01, 3'h0, 5'h00, 6'h00, 6'h00});
    chk("month roll", tout.month, 4'h1);
    chk("inval", inval_seen, 1'b1);
    chk("alarm", isr[1], 1'b1);
    chk("wake", wake, 1'b1);
    chk("irq", irq, 1'b1);
    chk("countdown", isr[2], 1'b1);
    chk("periodic", isr[9:3], 7'h7F);
    chk("clk 1hz", cko, 1'b1);
    chk("p512 run", c512, 1'b1);
    onb = 1'b1;
    step(5);
    ierd = 16'h0003;
    pulse(12'h010);
    step(3);
    chk("p512", c512, 1'b0);
    chk("ier", ier, 16'h0006);
    end_sim;
  end
endmodule // rtcb_top_tb
`default_nettype wire
